// ### rtl/adcsq_pkg.sv
// Purpose: Shared constants and types for the converter sequencer block
// Assumes: One 25 MHz clock, banked 16-bit extension register access
// Notes:   Control word field positions, bank map and sequencing timing
package adcsq_pkg;

    // Extension register map of the converter
    localparam logic [3:0] CTL_BANK = 4'hD;
    localparam logic [2:0] CTL_EXT = 3'h0;
    localparam logic [2:0] RES_EXT = 3'h6;
    localparam logic [3:0] BANK_CH0 = 4'h0;
    localparam logic [3:0] BANK_CH1 = 4'h1;
    localparam logic [3:0] BANK_CH2 = 4'h2;
    localparam logic [3:0] BANK_CH3 = 4'h3;
    localparam logic [3:0] BANK_ALT = 4'h5;
    localparam logic [3:0] BANK_CH0_LO = 4'h6;
    localparam logic [3:0] BANK_CH0_HI = 4'hD;
    localparam logic [2:0] ALT_EXT_CH1 = 3'h0;
    localparam logic [2:0] ALT_EXT_CH2 = 3'h1;
    localparam logic [2:0] ALT_EXT_CH3 = 3'h2;

    // converter_control field positions
    localparam int EN_BIT = 15;
    localparam int FLAG_BIT = 12;
    localparam int AFTER4_BIT = 11;
    localparam int IE_BIT = 10;
    localparam int TSEL_HI = 9;
    localparam int TSEL_LO = 8;
    localparam int DIV_HI = 7;
    localparam int DIV_LO = 5;
    localparam int MODE_HI = 4;
    localparam int MODE_LO = 3;
    localparam int CSEL_HI = 1;
    localparam int CSEL_LO = 0;
    // Writable bits: reserved 14:13, flag 12 and unused bit 2 stay zero
    localparam logic [15:0] CTL_WMASK = 16'h8FFB;
    localparam logic [15:0] CTL_RESET = 16'h0000;

    // Sequencing modes
    localparam logic [1:0] MODE_REPEAT4 = 2'b00;
    localparam logic [1:0] MODE_ONCE = 2'b01;
    localparam logic [1:0] MODE_SCAN_ONCE = 2'b10;
    localparam logic [1:0] MODE_SCAN_LOOP = 2'b11;

    // Start sources
    localparam logic [1:0] TRIG_WRITE = 2'b00;
    localparam logic [1:0] TRIG_EXT_IRQ = 2'b01;
    localparam logic [1:0] TRIG_GEN_TIMER = 2'b10;
    localparam logic [1:0] TRIG_TIMER0 = 2'b11;

    // Phase lengths in converter clock ticks, and conversion count of a four-conversion run
    localparam logic [2:0] AZ_TICKS = 3'h2;
    localparam logic [2:0] SMP_TICKS = 3'h2;
    localparam logic [2:0] CNV_TICKS = 3'h6;
    localparam logic [2:0] NCONV_QUAD = 3'h4;

    // Divider: step of eight input clocks per code
    localparam logic [2:0] DIV_LOW_BITS = 3'h7;

    typedef enum logic [1:0]
    {
        ST_IDLE = 2'b00,
        ST_AZERO = 2'b01,
        ST_SAMPLE = 2'b10,
        ST_CONVERT = 2'b11
    } adcsq_state_t;

endpackage : adcsq_pkg

// ### rtl/adcsq_prescale.sv
// Purpose: Converter clock divider, one-cycle tick every 8*(code+1) clocks
// Assumes: restart comes from logic on mclk
// Notes:   Restart realigns the tick so a fresh conversion gets full phases
module adcsq_prescale
    import adcsq_pkg::*;
(
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic [2:0] div_code,
    input wire logic restart,
    output logic tick
);

    typedef struct packed
    {
        logic [5:0] cnt;
        logic tick;
    } adcsq_div_t;

    adcsq_div_t s_r;
    adcsq_div_t s_nxt;
    logic [5:0] reload;

    // Period minus one is the code followed by three ones
    assign reload = {div_code, DIV_LOW_BITS};

    ////////////////////////////////////////////////////////////////////////
    // Down counter, tick on reaching zero
    always_comb
    begin
        s_nxt = s_r;
        s_nxt.tick = 1'b0;
        if (restart)
        begin
            s_nxt.cnt = reload;
        end
        else if (s_r.cnt == 6'h00)
        begin
            s_nxt.cnt = reload;   // Divide by 8..64
            s_nxt.tick = 1'b1;
        end
        else
        begin
            s_nxt.cnt = s_r.cnt - 6'h01;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (sys_rst)
            s_r <= '0;
        else
            s_r <= s_nxt;
    end

    assign tick = s_r.tick;

    ////////////////////////////////////////////////////////////////////////
    // Ticks never come closer than the smallest division
    a_tick_spacing: assert property (@(posedge mclk) disable iff (sys_rst)
        tick |=> !tick [*7])
        else $error("converter ticks closer than eight clocks");

endmodule : adcsq_prescale

// ### rtl/adcsq_seq.sv
// Purpose: Converter sequencer: triggers, modes, results and done flag
// Assumes: Converter core returns conv_data when convert phase ends
// Notes:   Bank select lives elsewhere; ext_rdata is zero when not hit

// How it works
// - Converter clock is input clock divided by 8 times (code plus one).
// - Bits 9:8 pick start: control write, irq line one, timer two, timer zero.
// - A start at any time aborts the running conversion and begins anew.
// - Bits 4:3: repeat four, once, scan four once, scan forever.
// - Repeat-four mode stores results into registers 0,1,2,3 in order.
// - Single and scan conversions store into that channel's own register.
// - Scans start at selected channel then ascend, wrapping 3 to 0.
// - Channel-select code 0..3 drives analog input 0..3.
// - Every conversion auto-zeroes the comparator before sampling.
// - Enable bit 15 low blocks conversions and all accesses but enabling.
// - Done flag bit 12 is read-only and cleared by a control write unless it sets in the same cycle.
// - Flag sets after first conversion, or fourth when bit 11 set.
// - Flag only sets while interrupt enable bit 10 is one.
// - Bits 14 and 13 are reserved and read zero.
// - Four result registers, one per channel, readable by the processor.
module adcsq_seq
    import adcsq_pkg::*;
(
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic [3:0] ext_bank,
    input wire logic [2:0] ext_addr,
    input wire logic ext_wr,
    input wire logic ext_rd,
    input wire logic [15:0] ext_wdata,
    output logic [15:0] ext_rdata,
    input wire logic external_irq_line_1,
    input wire logic general_timer_timeout,
    input wire logic timer_zero_timeout,
    input wire logic [7:0] conv_data,
    output logic [1:0] channel_mux,
    output logic converter_autozero,
    output logic converter_sample,
    output logic converter_convert,
    output logic conversion_done_flag
);

    typedef struct packed
    {
        logic [15:0] ctl;
        logic flag;
        adcsq_state_t st;
        logic [2:0] tcnt;
        logic [2:0] ndone;
        logic [1:0] chan;
        logic [3:0][7:0] res;
        logic sy1;
        logic sy2;
        logic sy3;
        logic [15:0] rdata;
        logic az;
        logic smp;
        logic cnv;
        logic [1:0] mux;
    } adcsq_seq_t;

    adcsq_seq_t s_r;
    adcsq_seq_t s_nxt;
    logic tick;
    logic ctl_wr;
    logic trig_now;
    logic done_now;
    logic [1:0] mode;
    logic [1:0] widx;
    logic [2:0] ndone_inc;
    logic [2:0] rhit;
    logic [2:0] div_sel;

    ////////////////////////////////////////////////////////////////////////
    // Result register decode: {hit, channel} for a bank and slot
    function automatic logic [2:0] res_decode(input logic [3:0] bank,
                                              input logic [2:0] addr);
        logic [2:0] r;
        r = 3'h0;
        if (addr == RES_EXT)
        begin
            case (bank)
                BANK_CH0: r = {1'b1, 2'h0};
                BANK_CH1: r = {1'b1, 2'h1};
                BANK_CH2: r = {1'b1, 2'h2};
                BANK_CH3: r = {1'b1, 2'h3};
                BANK_ALT: r = {1'b1, 2'h0};
                default:
                begin
                    if (bank >= BANK_CH0_LO && bank <= BANK_CH0_HI)
                        r = {1'b1, 2'h0};
                end
            endcase
        end
        else if (bank == BANK_ALT)
        begin
            case (addr)
                ALT_EXT_CH1: r = {1'b1, 2'h1};
                ALT_EXT_CH2: r = {1'b1, 2'h2};
                ALT_EXT_CH3: r = {1'b1, 2'h3};
                default: r = 3'h0;
            endcase
        end
        return r;
    endfunction : res_decode

    ////////////////////////////////////////////////////////////////////////
    // Converter clock; realigned on each start. A starting write must
    // reload with its own divider code, not the one it replaces.
    assign div_sel = (ctl_wr && ext_wdata[EN_BIT]) ?
        ext_wdata[DIV_HI:DIV_LO] : s_r.ctl[DIV_HI:DIV_LO];

    adcsq_prescale u_div
    (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .div_code(div_sel),
        .restart(trig_now),
        .tick(tick)
    );

    ////////////////////////////////////////////////////////////////////////
    // Start detection and completion
    assign ctl_wr = ext_wr && ext_bank == CTL_BANK && ext_addr == CTL_EXT;
    assign mode = s_r.ctl[MODE_HI:MODE_LO];
    assign rhit = res_decode(ext_bank, ext_addr);
    assign ndone_inc = s_r.ndone + 3'h1;
    // Repeat mode fills slots in order, others use the channel's own slot
    assign widx = (mode == MODE_REPEAT4) ? s_r.ndone[1:0] : s_r.chan;

    always_comb
    begin
        trig_now = 1'b0;
        if (ctl_wr)
        begin
            // A write starts only when it leaves the block enabled
            trig_now = ext_wdata[EN_BIT] &&
                ext_wdata[TSEL_HI:TSEL_LO] == TRIG_WRITE;
        end
        else if (s_r.ctl[EN_BIT])
        begin
            case (s_r.ctl[TSEL_HI:TSEL_LO])
                TRIG_EXT_IRQ: trig_now = s_r.sy2 && !s_r.sy3;
                TRIG_GEN_TIMER: trig_now = general_timer_timeout;
                TRIG_TIMER0: trig_now = timer_zero_timeout;
                default: trig_now = 1'b0;
            endcase
        end
    end

    assign done_now = s_r.st == ST_CONVERT && tick && !trig_now &&
        s_r.tcnt == CNV_TICKS - 3'h1 && !(ctl_wr && !ext_wdata[EN_BIT]);

    ////////////////////////////////////////////////////////////////////////
    // Next state of the whole block
    always_comb
    begin
        s_nxt = s_r;
        // Pin passes two flops before the edge detector looks at it
        s_nxt.sy1 = external_irq_line_1;
        s_nxt.sy2 = s_r.sy1;
        s_nxt.sy3 = s_r.sy2;

        // Control write; a write with the enable bit low only clears the enable bit
        if (ctl_wr)
        begin
            if (ext_wdata[EN_BIT])
                s_nxt.ctl = ext_wdata & CTL_WMASK;
            else
                s_nxt.ctl[EN_BIT] = 1'b0;
        end

        // Phase sequencing on converter ticks
        if (trig_now)
        begin
            s_nxt.st = ST_AZERO;
            s_nxt.tcnt = 3'h0;
            s_nxt.ndone = 3'h0;
            s_nxt.chan = ext_wdata[CSEL_HI:CSEL_LO];
            if (!ctl_wr)
                s_nxt.chan = s_r.ctl[CSEL_HI:CSEL_LO];
        end
        else if (!s_nxt.ctl[EN_BIT])
        begin
            s_nxt.st = ST_IDLE;
        end
        else if (tick)
        begin
            s_nxt.tcnt = s_r.tcnt + 3'h1;
            case (s_r.st)
                ST_AZERO:
                begin
                    if (s_r.tcnt == AZ_TICKS - 3'h1)
                    begin
                        s_nxt.st = ST_SAMPLE;
                        s_nxt.tcnt = 3'h0;
                    end
                end
                ST_SAMPLE:
                begin
                    if (s_r.tcnt == SMP_TICKS - 3'h1)
                    begin
                        s_nxt.st = ST_CONVERT;
                        s_nxt.tcnt = 3'h0;
                    end
                end
                ST_CONVERT:
                begin
                    if (done_now)
                    begin
                        s_nxt.tcnt = 3'h0;
                        s_nxt.res[widx] = conv_data;
                        if (s_r.ndone != NCONV_QUAD)
                            s_nxt.ndone = ndone_inc;
                        // Each new conversion goes back through auto-zero
                        s_nxt.st = ST_AZERO;
                        case (mode)
                            MODE_ONCE: s_nxt.st = ST_IDLE;
                            MODE_REPEAT4:
                            begin
                                if (ndone_inc == NCONV_QUAD)
                                    s_nxt.st = ST_IDLE;
                            end
                            MODE_SCAN_ONCE:
                            begin
                                s_nxt.chan = s_r.chan + 2'h1;
                                if (ndone_inc == NCONV_QUAD)
                                    s_nxt.st = ST_IDLE;
                            end
                            default: s_nxt.chan = s_r.chan + 2'h1;
                        endcase
                    end
                end
                default: s_nxt.tcnt = 3'h0;
            endcase
        end

        // Done flag: the set wins over a clearing write
        if (ctl_wr)
            s_nxt.flag = 1'b0;
        if (done_now && s_r.ctl[IE_BIT])
        begin
            if (s_r.ctl[AFTER4_BIT] ? ndone_inc == NCONV_QUAD
                                    : s_r.ndone == 3'h0)
                s_nxt.flag = 1'b1;
        end

        // Read port, all reads blocked while disabled
        s_nxt.rdata = 16'h0000;
        if (ext_rd && s_r.ctl[EN_BIT])
        begin
            if (ext_bank == CTL_BANK && ext_addr == CTL_EXT)
                s_nxt.rdata = {s_r.ctl[15:13], s_r.flag,
                               s_r.ctl[11:0]};
            else if (rhit[2])
                s_nxt.rdata = {8'h00, s_r.res[rhit[1:0]]};
        end

        // Converter strobes follow the registered state
        s_nxt.az = s_nxt.st == ST_AZERO;
        s_nxt.smp = s_nxt.st == ST_SAMPLE;
        s_nxt.cnv = s_nxt.st == ST_CONVERT;
        s_nxt.mux = s_nxt.chan;
    end

    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            s_r <= '0;
            s_r.ctl <= CTL_RESET;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    assign ext_rdata = s_r.rdata;
    assign channel_mux = s_r.mux;
    assign converter_autozero = s_r.az;
    assign converter_sample = s_r.smp;
    assign converter_convert = s_r.cnv;
    assign conversion_done_flag = s_r.flag;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);

    sequence s_start;
        trig_now;
    endsequence
    sequence s_fresh_azero;
        s_r.st == ST_AZERO && s_r.tcnt == 3'h0 && s_r.ndone == 3'h0;
    endsequence

    a_start_restarts: assert property (s_start |=> s_fresh_azero)
        else $error("start did not restart the conversion");
    a_sample_after_zero: assert property ($rose(converter_sample)
        |-> $past(converter_autozero))
        else $error("sampling without auto-zero");
    a_busy_needs_enable: assert property (s_r.st != ST_IDLE
        |-> s_r.ctl[EN_BIT])
        else $error("converter running while disabled");
    a_write_clears_flag: assert property (ctl_wr && !done_now
        |=> !conversion_done_flag)
        else $error("control write left done flag set");
    a_flag_first_done: assert property (done_now && s_r.ctl[IE_BIT] &&
        !s_r.ctl[AFTER4_BIT] && s_r.ndone == 3'h0
        |=> conversion_done_flag)
        else $error("flag missing after first conversion");
    a_flag_needs_ie: assert property ($rose(conversion_done_flag)
        |-> $past(s_r.ctl[IE_BIT]))
        else $error("flag set with interrupts disabled");
    a_once_stops: assert property (done_now && mode == MODE_ONCE
        |=> s_r.st == ST_IDLE)
        else $error("single mode did not stop");
    a_scan_ascends: assert property (done_now && mode[1]
        |=> s_r.chan == $past(s_r.chan) + 2'h1)
        else $error("scan channel order wrong");
    a_result_stored: assert property (done_now
        |=> s_r.res[$past(widx)] == $past(conv_data))
        else $error("result not stored in its slot");
    a_read_upper_zero: assert property (ext_rd && rhit[2]
        |=> ext_rdata[15:8] == 8'h00)
        else $error("result upper byte not zero");
    a_reserved_zero: assert property (ext_rd
        |=> ext_rdata[14:13] == 2'b00)
        else $error("reserved bits read nonzero");

endmodule : adcsq_seq

// ### testbench/adcsq_core_model.sv
// Purpose: Behavioural converter core facing the sequencer
// Assumes: Result is sampled by the sequencer at the end of convert
// Notes:   Data carries a conversion count so slot order is visible
module adcsq_core_model
    import adcsq_pkg::*;
(
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic [1:0] channel_mux,
    input wire logic converter_convert,
    output logic [7:0] conv_data
);
    timeunit 1ns;
    timeprecision 1ps;
    logic conv_d;
    logic [3:0] seq;
    logic [7:0] last;

    ////////////////////////////////////////////////////////////////////////
    // Count convert phases, remember the last value put out
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            conv_d <= 1'b0;
            seq <= 4'h0;
            last <= 8'h00;
        end
        else
        begin
            conv_d <= converter_convert;
            if (converter_convert && !conv_d)
                seq <= seq + 4'h1;
            if (converter_convert)
                last <= conv_data;
        end
    end

    // Outside convert the line shows junk, not a held value
    assign conv_data = converter_convert ? {seq, 2'b00, channel_mux}
                                         : ~last;
endmodule : adcsq_core_model

// ### testbench/adc_sequencer_control_test.sv
// Purpose: Self-checking bench for the converter sequencer
// Assumes: Banked extension bus, one write or read strobe per access
// Notes:   Expected results come from a count of convert phases
module adc_sequencer_control_test;
    timeunit 1ns;
    timeprecision 1ps;
    import adcsq_pkg::*;

    logic mclk = 0, sys_rst = 1, ext_wr = 0, ext_rd = 0;
    logic [3:0] ext_bank = 4'h0;
    logic [2:0] ext_addr = 3'h0;
    logic [15:0] ext_wdata = 16'h0000, ext_rdata, d;
    logic irq1 = 0, gtm = 0, tm0 = 0;
    logic [7:0] conv_data;
    logic [1:0] channel_mux;
    logic az, smp, cv, flag, cv_d, az_d, smp_d;
    logic [1:0] ch_log [0:63];
    int errors = 0, n_compared = 0, conv_n = 0, cycles = 0, base, n;

    always #20 mclk = ~mclk;

    adcsq_seq i_adcsq_seq (.mclk(mclk), .sys_rst(sys_rst),
        .ext_bank(ext_bank), .ext_addr(ext_addr), .ext_wr(ext_wr),
        .ext_rd(ext_rd), .ext_wdata(ext_wdata), .ext_rdata(ext_rdata),
        .external_irq_line_1(irq1), .general_timer_timeout(gtm),
        .timer_zero_timeout(tm0), .conv_data(conv_data),
        .channel_mux(channel_mux), .converter_autozero(az),
        .converter_sample(smp), .converter_convert(cv),
        .conversion_done_flag(flag));

    adcsq_core_model i_adcsq_core_model (.mclk(mclk), .sys_rst(sys_rst),
        .channel_mux(channel_mux), .converter_convert(cv),
        .conv_data(conv_data));

    ////////////////////////////////////////////////////////////////////////
    // Monitor: log channel per conversion, sampling must follow auto-zero
    always @(posedge mclk)
    begin
        cv_d <= cv;
        az_d <= az;
        smp_d <= smp;
        if (sys_rst)
            conv_n <= 0;
        else if (cv && !cv_d)
        begin
            ch_log[conv_n % 64] <= channel_mux;
            conv_n <= conv_n + 1;
        end
        if (smp && !smp_d && !az_d)
        begin
            errors++;
            $display("wrong value at %0t: sample without auto-zero", $time);
        end
        if (smp && !smp_d)
            n_compared++;
    end

    // Hang guard, far above the few thousand cycles the tests need
    always @(posedge mclk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            errors++;
            results();
        end
    end

    task results;
        $display("compared %0d, errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : results

    task chk(input logic [15:0] g, input logic [15:0] e, input string m);
        n_compared++;
        if (g !== e)
        begin
            errors++;
            $display("wrong value at %0t: %s got %h exp %h", $time, m, g, e);
        end
    endtask : chk

    task wr(input logic [3:0] b, input logic [2:0] a, input logic [15:0] v);
        @(negedge mclk);
        ext_bank = b;
        ext_addr = a;
        ext_wdata = v;
        ext_wr = 1;
        @(negedge mclk);
        ext_wr = 0;
    endtask : wr

    task rd(input logic [3:0] b, input logic [2:0] a,
            output logic [15:0] v);
        @(negedge mclk);
        ext_bank = b;
        ext_addr = a;
        ext_rd = 1;
        @(negedge mclk);
        ext_rd = 0;
        v = ext_rdata;
    endtask : rd

    task ctl(input logic [15:0] v);
        wr(CTL_BANK, CTL_EXT, v);
    endtask : ctl

    // One-cycle start pulse on source s (1 line one, 2 timer two, 3 zero)
    task pulse(input int s);
        @(negedge mclk);
        irq1 = (s == 1);
        gtm = (s == 2);
        tm0 = (s == 3);
        @(negedge mclk);
        {irq1, gtm, tm0} = 3'b000;
    endtask : pulse

    task wait_idle;
        int i;
        i = 0;
        while ((az || smp || cv) && i < 8000)
        begin
            @(negedge mclk);
            i++;
        end
        chk(16'(i < 8000), 16'h0001, "sequencer stuck");
    endtask : wait_idle

    task wait_az(input int lim);
        int i;
        i = 0;
        while (!az && i < lim)
        begin
            @(negedge mclk);
            i++;
        end
        chk(16'(az), 16'h0001, "no start");
    endtask : wait_az

    function automatic logic [15:0] res(input int k, input logic [1:0] c);
        return {8'h00, 4'(k), 2'b00, c};
    endfunction : res

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (20) @(negedge mclk);
        sys_rst = 0;
        // Disabled block refuses everything but enabling
        rd(CTL_BANK, CTL_EXT, d);
        chk(d, 16'h0000, "disabled ctl read");
        ctl(16'h7FFB);
        repeat (3) @(negedge mclk);
        chk(16'(az), 16'h0000, "start while disabled");
        $display("test disabled done");

        // Every divider code: sample and convert lengths and channel decode
        for (int c = 0; c < 8; c++)
        begin
            ctl(16'h8000 | (16'(c) << DIV_LO) | (16'(MODE_ONCE) << 3)
                | 16'(c % 4));
            chk(16'(channel_mux), 16'(c % 4), "mux");
            while (!smp) @(negedge mclk);
            n = 0;
            while (smp) begin n++; @(negedge mclk); end
            chk(16'(n), 16'(16 * (c + 1)), "sample len");
            n = 0;
            while (cv) begin n++; @(negedge mclk); end
            chk(16'(n), 16'(48 * (c + 1)), "convert len");
            wait_idle();
            rd(4'(c % 4), RES_EXT, d);
            chk(d, res(conv_n, 2'(c)), "own result");
        end
        $display("test divider done");

        // Repeat four on input 1, flag after the fourth
        base = conv_n;
        ctl(16'h8000 | 16'h0C00 | 16'(MODE_REPEAT4) << 3 | 16'h0001);
        while (conv_n < base + 2) @(negedge mclk);
        chk(16'(flag), 16'h0000, "early flag");
        wait_idle();
        chk(16'(flag), 16'h0001, "flag after four");
        rd(BANK_CH0, RES_EXT, d);
        chk(d, res(base + 1, 2'd1), "slot 0");
        rd(4'h9, RES_EXT, d);
        chk(d, res(base + 1, 2'd1), "slot 0 alias");
        for (int k = 0; k < 3; k++)
        begin
            rd(BANK_ALT, 3'(k), d);
            chk(d, res(base + k + 2, 2'd1), "slot 1 to 3");
        end
        rd(CTL_BANK, CTL_EXT, d);
        chk(d, 16'h9C01, "ctl with flag");
        ctl(16'h8000 | 16'(TRIG_GEN_TIMER) << 8);
        rd(CTL_BANK, CTL_EXT, d);
        chk(d, 16'h8200, "flag cleared");
        chk(16'(az), 16'h0000, "write start off");
        $display("test repeat four done");

        // Each hardware start source, a wrong source ignored
        for (int t = 1; t < 4; t++)
        begin
            ctl(16'h8000 | 16'(t) << 8 | 16'(MODE_ONCE) << 3 | 16'h0003);
            pulse(t == 3 ? 1 : t + 1);
            repeat (5) @(negedge mclk);
            chk(16'(az), 16'h0000, "wrong source");
            pulse(t);
            wait_az(6);
            wait_idle();
        end
        $display("test triggers done");

        // Restart in mid-convert begins a fresh conversion
        ctl(16'h8000 | 16'(TRIG_GEN_TIMER) << 8 | 16'(MODE_ONCE) << 3);
        pulse(2);
        while (!cv) @(negedge mclk);
        pulse(2);
        wait_az(6);
        chk(16'(cv), 16'h0000, "old convert kept");
        wait_idle();
        rd(BANK_CH0, RES_EXT, d);
        chk(d, res(conv_n, 2'd0), "fresh result");
        $display("test abort done");

        // Scan once from input 3, interrupts off
        base = conv_n;
        ctl(16'h8800 | 16'(MODE_SCAN_ONCE) << 3 | 16'h0003);
        wait_idle();
        chk(16'(conv_n - base), 16'h0004, "scan count");
        for (int k = 0; k < 4; k++)
        begin
            chk(16'(ch_log[base + k]), 16'((3 + k) % 4), "order");
            rd(4'((3 + k) % 4), RES_EXT, d);
            chk(d, res(base + k + 1, 2'(3 + k)), "scan res");
        end
        chk(16'(flag), 16'h0000, "flag with ie off");
        $display("test scan once done");

        // Endless scan, then disable stops it
        base = conv_n;
        ctl(16'h8400 | 16'(MODE_SCAN_LOOP) << 3);
        n = 0;
        while (conv_n < base + 6 && n < 3000) begin n++; @(negedge mclk); end
        chk(16'(conv_n >= base + 6), 16'h0001, "scan loop");
        chk(16'(flag), 16'h0001, "flag after first");
        ctl(16'h0000);
        @(negedge mclk);
        chk(16'(az | smp | cv), 16'h0000, "stop on disable");
        rd(BANK_CH1, RES_EXT, d);
        chk(d, 16'h0000, "disabled result");
        ctl(16'h8000);
        rd(4'h7, 3'h3, d);
        chk(d, 16'h0000, "unmapped");
        $display("test scan loop done");
        results();
    end
endmodule : adc_sequencer_control_test
